/* File: logic/lcdvc_map.vh */
// register map, field positions and fixed values of the supply code converter
`ifndef LCDVC_MAP_VH
`define LCDVC_MAP_VH
`define LCDVC_ADDR_CONFIG 12'h000
`define LCDVC_ADDR_OTP_CAL 12'h004
`define LCDVC_ADDR_OP_CODE 12'h008
`define LCDVC_ADDR_SUM_CODE 12'h00c
`define LCDVC_ADDR_SUPPLY 12'h010
`define LCDVC_ADDR_REF_TEMP 12'h014
`define LCDVC_CFG_LEVEL_LSB 0
`define LCDVC_CFG_CLASS_LSB 8
`define LCDVC_CFG_USE_OTP 16
`define LCDVC_RST_LEVEL 6'h00
`define LCDVC_RST_CLASS 3'h0
`define LCDVC_RST_OTP 5'h00
`define LCDVC_OP_MAX 8'hff
`define LCDVC_BASE_MV 16'h0bb8
`define LCDVC_STEP_MV 16'h001e
`define LCDVC_REF_TEMP_C 8'h28
`define LCDVC_SLOPE_ROUND 10'h008
`define LCDVC_SLOPE_SHIFT 4
`endif

/* File: logic/lcdvc_converter.v */
// supply code converter: contrast level lookup, offset add and supply level
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "lcdvc_map.vh"
// Functional notes
// [R1] basic set: 8-bit operating code looked up from 6-bit level and 3-bit class
// [R2] 5-bit offset added to operating code; the sum sets the supply level
// [R3] pad method: offset taken from the offset bonding pads
// [R4] otp method: offset taken from the calibration cells instead
// [R5] supply level is 3 V when the summed code is zero
// [R6] each count of the summed code adds 0.03 V
// [R7] the code to level relation holds at the 40 degC reference temperature
// [R8] table output saturates at its maximum entry instead of wrapping
module lcdvc_converter
#(
   parameter LEVEL_W = 6,
   parameter CLASS_W = 3,
   parameter OFFS_W = 5,
   parameter OP_W = 8
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [OFFS_W-1:0] pad_supply_offset,
   output reg [OP_W-1:0] operating_voltage_code,
   output reg [OP_W:0] summed_supply_code,
   output reg [15:0] lcd_supply_level
);
   reg [LEVEL_W-1:0] contrast_level_code_ff;
   reg [CLASS_W-1:0] offset_class_select_ff;
   reg otp_select_ff;
   reg [OFFS_W-1:0] otp_supply_calibration_ff;
   reg [OFFS_W-1:0] pad_s1_ff;
   reg [OFFS_W-1:0] pad_s2_ff;
   reg [OFFS_W-1:0] pad_s3_ff;
   reg [OFFS_W-1:0] pad_offset_ff;
   reg [OP_W-1:0] nxt_op;
   reg [9:0] base;
   reg [5:0] slope;
   reg [15:0] prod;
   reg [9:0] raw;
   reg [11:0] scaled;
   wire [OFFS_W-1:0] sel_offset;
   wire [OP_W:0] nxt_sum;
   wire [15:0] nxt_level;
   wire wr_en;
   wire rd_en;
   reg addr_ok;

   // apb handshake, single cycle access phase
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign pslverr = psel & penable & ~addr_ok;

   // address decode
   always @*
   begin
      case (paddr)
         `LCDVC_ADDR_CONFIG,
         `LCDVC_ADDR_OTP_CAL,
         `LCDVC_ADDR_OP_CODE,
         `LCDVC_ADDR_SUM_CODE,
         `LCDVC_ADDR_SUPPLY,
         `LCDVC_ADDR_REF_TEMP:
            addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // register writes
   // writes to read-only or unmapped words are dropped
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         contrast_level_code_ff <= `LCDVC_RST_LEVEL;
         offset_class_select_ff <= `LCDVC_RST_CLASS;
         otp_select_ff <= 1'b0;
         otp_supply_calibration_ff <= `LCDVC_RST_OTP;
      end
      else if (wr_en)
      begin
         if (paddr == `LCDVC_ADDR_CONFIG)
         begin
            contrast_level_code_ff <= pwdata[`LCDVC_CFG_LEVEL_LSB +: LEVEL_W];
            offset_class_select_ff <= pwdata[`LCDVC_CFG_CLASS_LSB +: CLASS_W];
            otp_select_ff <= pwdata[`LCDVC_CFG_USE_OTP];
         end
         if (paddr == `LCDVC_ADDR_OTP_CAL)
            otp_supply_calibration_ff <= pwdata[OFFS_W-1:0]; // R4
      end
   end

   // pad synchroniser, a change counts when stages two and three agree
   // only stage two reads stage one, which may still be settling
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pad_s1_ff <= {OFFS_W{1'b0}};
         pad_s2_ff <= {OFFS_W{1'b0}};
         pad_s3_ff <= {OFFS_W{1'b0}};
         pad_offset_ff <= {OFFS_W{1'b0}};
      end
      else
      begin
         pad_s1_ff <= pad_supply_offset;
         pad_s2_ff <= pad_s1_ff;
         pad_s3_ff <= pad_s2_ff;
         if (pad_s2_ff == pad_s3_ff)
            pad_offset_ff <= pad_s3_ff; // R3
      end
   end

   // conversion table: per class start code and slope in sixteenths
   // the rom is modelled as start code plus rounded level times slope
   always @*
   begin
      case (offset_class_select_ff)
         3'h0:
         begin
            base = 10'h00d;
            slope = 6'h0d;
         end
         3'h1:
         begin
            base = 10'h030;
            slope = 6'h10;
         end
         3'h2:
         begin
            base = 10'h052;
            slope = 6'h13;
         end
         3'h3:
         begin
            base = 10'h074;
            slope = 6'h17;
         end
         3'h4:
         begin
            base = 10'h096;
            slope = 6'h1b;
         end
         3'h5:
         begin
            base = 10'h0b9;
            slope = 6'h1f;
         end
         3'h6:
         begin
            base = 10'h0db;
            slope = 6'h23;
         end
         default:
         begin
            base = 10'h0fd;
            slope = 6'h27;
         end
      endcase
      // product needs twelve bits: top level times top slope is above 1023
      prod = {{(16-LEVEL_W){1'b0}}, contrast_level_code_ff} * {10'h000, slope};
      scaled = (prod[11:0] + {2'b00, `LCDVC_SLOPE_ROUND}) >> `LCDVC_SLOPE_SHIFT;
      raw = base + scaled[9:0]; // R1
      if (raw > {2'b00, `LCDVC_OP_MAX})
         nxt_op = `LCDVC_OP_MAX; // R8
      else
         nxt_op = raw[OP_W-1:0];
   end

   // offset source and sum
   assign sel_offset = otp_select_ff ? otp_supply_calibration_ff : pad_offset_ff; // R3 R4
   assign nxt_sum = {1'b0, nxt_op} + {{(OP_W+1-OFFS_W){1'b0}}, sel_offset}; // R2
   // supply level in millivolts at the reference temperature
   assign nxt_level = `LCDVC_BASE_MV + `LCDVC_STEP_MV * {{(15-OP_W){1'b0}}, nxt_sum}; // R5 R6 R7

   // registered outputs
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         operating_voltage_code <= {OP_W{1'b0}};
         summed_supply_code <= {(OP_W+1){1'b0}};
         lcd_supply_level <= `LCDVC_BASE_MV;
      end
      else
      begin
         operating_voltage_code <= nxt_op; // R1
         summed_supply_code <= nxt_sum; // R2
         lcd_supply_level <= nxt_level; // R5 R6
      end
   end

   // read mux
   always @*
   begin
      prdata = 32'h0000_0000;
      if (rd_en)
      begin
         case (paddr)
            `LCDVC_ADDR_CONFIG:
            begin
               prdata[`LCDVC_CFG_LEVEL_LSB +: LEVEL_W] = contrast_level_code_ff;
               prdata[`LCDVC_CFG_CLASS_LSB +: CLASS_W] = offset_class_select_ff;
               prdata[`LCDVC_CFG_USE_OTP] = otp_select_ff;
            end
            `LCDVC_ADDR_OTP_CAL: prdata[OFFS_W-1:0] = otp_supply_calibration_ff;
            `LCDVC_ADDR_OP_CODE: prdata[OP_W-1:0] = operating_voltage_code;
            `LCDVC_ADDR_SUM_CODE: prdata[OP_W:0] = summed_supply_code;
            `LCDVC_ADDR_SUPPLY: prdata[15:0] = lcd_supply_level;
            `LCDVC_ADDR_REF_TEMP: prdata[7:0] = `LCDVC_REF_TEMP_C; // R7
            default: prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: bench/lcdvc_pads.sv */
// bonding pad model for the supply offset pins
`timescale 1ns/10ps
`default_nettype none
module lcdvc_pads(
   input wire logic [4:0] pad_val,
   output wire logic [4:0] pad_supply_offset
);
   // strapped pad levels
   assign pad_supply_offset = pad_val;
endmodule
`default_nettype wire

/* File: bench/lcdvc_chk.sv */
// port checker of the supply code converter
`timescale 1ns/10ps
`default_nettype none
`include "lcdvc_map.vh"
module lcdvc_chk(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [7:0] operating_voltage_code,
   input wire logic [8:0] summed_supply_code,
   input wire logic [15:0] lcd_supply_level
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic rd_acc = psel && penable && !pwrite;
   // level follows the summed code
   a_supply_step: assert property ($stable(summed_supply_code)[*2] |->
      lcd_supply_level == `LCDVC_BASE_MV + `LCDVC_STEP_MV * summed_supply_code) else $error("level");
   a_sum_over: assert property ($stable(operating_voltage_code)[*3] |->
      summed_supply_code >= operating_voltage_code) else $error("sum low");
   a_sum_under: assert property ($stable(operating_voltage_code)[*3] |->
      summed_supply_code <= operating_voltage_code + 9'h01f) else $error("sum high");
   // register reads mirror the outputs and the reference temperature; accesses above 0x014 flag an error
   a_temp_read: assert property (rd_acc && paddr == `LCDVC_ADDR_REF_TEMP |->
      prdata == {24'h000000, `LCDVC_REF_TEMP_C}) else $error("temp");
   a_op_read: assert property (rd_acc && paddr == `LCDVC_ADDR_OP_CODE |->
      prdata == {24'h000000, operating_voltage_code}) else $error("op read");
   a_sum_read: assert property (rd_acc && paddr == `LCDVC_ADDR_SUM_CODE |->
      prdata == {23'h000000, summed_supply_code}) else $error("sum read");
   a_level_read: assert property (rd_acc && paddr == `LCDVC_ADDR_SUPPLY |->
      prdata == {16'h0000, lcd_supply_level}) else $error("level read");
   a_err_unmapped: assert property (psel && penable && paddr > 12'h014 |->
      pslverr && prdata == 32'h0) else $error("unmapped");
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// testbench of the supply code converter
`timescale 1ns/10ps
`default_nettype none
`include "lcdvc_map.vh"
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [4:0] pad_val = 5'h00;
   wire logic pready, pslverr;
   wire logic [31:0] prdata;
   wire logic [4:0] pad_supply_offset;
   wire logic [7:0] op;
   wire logic [8:0] sum;
   wire logic [15:0] lvl;
   int fails = 0, n_compared = 0, cyc = 0;
   // clock
   always #5 pclk = ~pclk;
   lcdvc_pads pads (.pad_val(pad_val), .pad_supply_offset(pad_supply_offset));
   lcdvc_converter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_supply_offset(pad_supply_offset),
      .operating_voltage_code(op), .summed_supply_code(sum), .lcd_supply_level(lvl));
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task expo(input logic [8:0] o, input logic [8:0] f);
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      chk(op, o);
      chk(sum, o + f);
      chk(lvl, 16'h0bb8 + 16'h001e * (o + f));
      apb(1'b0, `LCDVC_ADDR_SUPPLY, 32'h0);
      chk(rd, 16'h0bb8 + 16'h001e * (o + f));
   endtask
   task t_regs;
      apb(1'b0, `LCDVC_ADDR_CONFIG, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `LCDVC_ADDR_REF_TEMP, 32'h0);
      chk(rd, 32'h28);
      apb(1'b1, `LCDVC_ADDR_OP_CODE, 32'h55);
      apb(1'b0, 12'h100, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      expo(9'h00d, 9'h000);
   endtask
   task t_otp;
      apb(1'b1, `LCDVC_ADDR_OTP_CAL, 32'h1f);
      apb(1'b1, `LCDVC_ADDR_CONFIG, 32'h1020f);
      apb(1'b0, `LCDVC_ADDR_OTP_CAL, 32'h0);
      chk(rd, 32'h1f);
      expo(9'h064, 9'h01f);
   endtask
   task t_pads;
      apb(1'b1, `LCDVC_ADDR_CONFIG, 32'h020f);
      expo(9'h064, 9'h000);
      pad_val <= 5'h05;
      expo(9'h064, 9'h005);
   endtask
   task t_sat;
      apb(1'b1, `LCDVC_ADDR_CONFIG, 32'h073f);
      expo(9'h0ff, 9'h005);
      apb(1'b1, `LCDVC_ADDR_CONFIG, 32'h061e);
      expo(9'h0ff, 9'h005);
      apb(1'b1, `LCDVC_ADDR_CONFIG, 32'h0700);
      expo(9'h0fd, 9'h005);
   endtask
   // mid-run reset: outputs fall back, then level 0 class 0 with pads
   task t_reset;
      presetn <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk(op, 32'h0);
      chk(sum, 32'h0);
      chk(lvl, 32'h0bb8);
      @(posedge pclk);
      presetn <= 1'b1;
      expo(9'h00d, 9'h005);
   endtask
   // main sequence
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_pads;
      t_otp;
      t_sat;
      t_reset;
      wrap_up;
   end
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         fails++;
         wrap_up;
      end
   end
endmodule
bind lcdvc_converter lcdvc_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .operating_voltage_code(operating_voltage_code), .summed_supply_code(summed_supply_code),
   .lcd_supply_level(lcd_supply_level));
`default_nettype wire
